// ---- design/wmog_cfg.svh ----
// Register offsets, field positions and reset values of the marker gate
`ifndef WMOG_CFG_SVH
`define WMOG_CFG_SVH
`define WMOG_ADR_CTRL      8'h00
`define WMOG_ADR_SEG_SEL   8'h04
`define WMOG_ADR_SEG_EN    8'h08
`define WMOG_ADR_STATUS    8'h0C
`define WMOG_CTRL_POL_LSB  0
`define WMOG_CTRL_RTE_BIT  4
`define WMOG_CTRL_RSEL_LSB 5
`define WMOG_STS_EVT_LSB   0
`define WMOG_STS_SUP_BIT   4
`define WMOG_STS_HOLD_BIT  5
`define WMOG_STS_SEG_LSB   8
`define WMOG_POL_RST       4'h0
`define WMOG_SEG_EN_RST    4'hF
`endif

// ---- design/wmog_marker_gate.sv ----
// Marker output gating with per-segment enables, polarity and blanking
// Functional notes
// - Enabled set marker point drives its event output
// - Separate enable per marker per segment
// - Disabled markers stay inactive for whole segment
// - Enabling marker without points changes nothing
// - Enables survive sequence change, lost at reset
// - Factory segments mark first sample, all markers
// - Routed marker low suppresses carrier output
// - Carrier suppression also holds the level loop
// - Negative polarity inverts marker output
// - Independent polarity per marker, default positive
// - Positive polarity: set point drives high
// - Negative polarity: set point drives low
// - No set points: positive output holds low
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "wmog_cfg.svh"

module wmog_marker_gate #(
  parameter int SEG_W = 4
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  output logic                          wb_ack_o,
  output logic [31:0]                   wb_dat_o,
  input  wire logic                     sample_en_i,
  input  wire logic                     playing_i,
  input  wire logic                     seq_load_i,
  input  wire logic [SEG_W-1:0]         seg_idx_i,
  input  wire wmog_pkg::wmog_sample_type sample_i,
  output logic [3:0]                    event_o,
  output logic                          carrier_suppress_o,
  output logic                          level_loop_hold_o
);
  localparam int SEG_NUM = 1 << SEG_W;

  wmog_pkg::wmog_ctrl_type ctrl_q;
  logic [SEG_W-1:0]        seg_sel_q;
  logic [3:0]              seg_en_q [SEG_NUM];
  logic                    ack_q;
  logic [31:0]             dat_q;
  logic [31:0]             rd_d;
  logic                    req;
  logic                    wr_go;
  logic [3:0]              eff_bits;
  logic [3:0]              en_cur;
  logic [3:0]              active_d;
  logic [3:0]              event_d;
  logic                    suppress_d;

  // Bus slave: one wait state, ack drops the cycle after it is given
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & ack_q & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      `WMOG_ADR_CTRL: begin
        rd_d[`WMOG_CTRL_POL_LSB +: 4]  = ctrl_q.pol_neg;
        rd_d[`WMOG_CTRL_RTE_BIT]       = ctrl_q.route_en;
        rd_d[`WMOG_CTRL_RSEL_LSB +: 2] = ctrl_q.route_sel;
      end
      `WMOG_ADR_SEG_SEL: rd_d[SEG_W-1:0] = seg_sel_q;
      `WMOG_ADR_SEG_EN:  rd_d[3:0] = seg_en_q[seg_sel_q];
      `WMOG_ADR_STATUS: begin
        rd_d[`WMOG_STS_EVT_LSB +: 4]     = event_o;
        rd_d[`WMOG_STS_SUP_BIT]          = carrier_suppress_o;
        rd_d[`WMOG_STS_HOLD_BIT]         = level_loop_hold_o;
        rd_d[`WMOG_STS_SEG_LSB +: SEG_W] = seg_idx_i;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~ack_q) begin
      dat_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Control register: polarity and carrier suppress routing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q.pol_neg   <= `WMOG_POL_RST;
      ctrl_q.route_en  <= 1'b0;
      ctrl_q.route_sel <= 2'h0;
    end else if (wr_go && wb_adr_i == `WMOG_ADR_CTRL) begin
      ctrl_q.pol_neg   <= wb_dat_i[`WMOG_CTRL_POL_LSB +: 4];
      ctrl_q.route_en  <= wb_dat_i[`WMOG_CTRL_RTE_BIT];
      ctrl_q.route_sel <= wb_dat_i[`WMOG_CTRL_RSEL_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seg_sel_q <= '0;
    end else if (wr_go && wb_adr_i == `WMOG_ADR_SEG_SEL) begin
      seg_sel_q <= wb_dat_i[SEG_W-1:0];
    end
  end

  // Enable table is only touched by reset or an explicit write;
  // a sequence load deliberately leaves it alone.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int s = 0; s < SEG_NUM; s++) begin
        seg_en_q[s] <= `WMOG_SEG_EN_RST;
      end
    end else if (wr_go && wb_adr_i == `WMOG_ADR_SEG_EN) begin
      seg_en_q[seg_sel_q] <= wb_dat_i[3:0];
    end
  end

  // Marker datapath
  always_comb begin
    eff_bits = sample_i.bits;
    if (sample_i.factory && sample_i.first) begin
      eff_bits = 4'hF;
    end
  end

  assign en_cur   = seg_en_q[seg_idx_i];
  // A marker with no set point stays inactive even when enabled
  assign active_d = playing_i ? (eff_bits & en_cur) : 4'h0;
  // Inactive positive marker sits low; negative flips the level
  assign event_d  = active_d ^ ctrl_q.pol_neg;
  // Suppression follows the routed marker's output level
  assign suppress_d = ctrl_q.route_en & ~event_d[ctrl_q.route_sel];

  // Outputs move only on a sample strobe so they line up with the
  // sample carrying the marker bit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_o            <= 4'h0;
      carrier_suppress_o <= 1'b0;
      level_loop_hold_o  <= 1'b0;
    end else if (sample_en_i) begin
      event_o            <= event_d;
      carrier_suppress_o <= suppress_d;
      level_loop_hold_o  <= suppress_d;
    end
  end

  // Checks
  for (genvar i = 0; i < 4; i++) begin : g_chk
    a_marker_drive: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && playing_i && eff_bits[i] && en_cur[i]
      |=> event_o[i] == !$past(ctrl_q.pol_neg[i]))
      else $error("enabled marker point not driven");

    a_seg_disabled: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && !en_cur[i]
      |=> event_o[i] == $past(ctrl_q.pol_neg[i]))
      else $error("disabled marker produced output");

    a_no_points: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && !eff_bits[i] && !ctrl_q.pol_neg[i]
      |=> !event_o[i])
      else $error("positive marker without point not low");

    a_factory_first: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && playing_i && sample_i.factory && sample_i.first
      && en_cur[i] |=> event_o[i] != $past(ctrl_q.pol_neg[i]))
      else $error("factory first sample not marked");

    a_pos_high: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && active_d[i] && !ctrl_q.pol_neg[i]
      |=> event_o[i])
      else $error("positive marker point not high");

    a_neg_low: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && active_d[i] && ctrl_q.pol_neg[i]
      |=> !event_o[i])
      else $error("negative marker point not low");

    a_neg_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && !active_d[i] && ctrl_q.pol_neg[i]
      |=> event_o[i])
      else $error("negative idle marker not high");

    a_not_play: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && !playing_i
      |=> event_o[i] == $past(ctrl_q.pol_neg[i]))
      else $error("marker active while not playing");

    a_need_point: assert property (@(posedge clk_i) disable iff (rst_i)
      sample_en_i && !eff_bits[i]
      |=> event_o[i] == $past(ctrl_q.pol_neg[i]))
      else $error("marker without point changed output");

    a_en_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_go && wb_adr_i == `WMOG_ADR_SEG_EN
      |=> seg_en_q[$past(seg_sel_q)][i] == $past(wb_dat_i[i]))
      else $error("segment enable write lost");

    a_pol_write: assert property (@(posedge clk_i) disable iff (rst_i)
      wr_go && wb_adr_i == `WMOG_ADR_CTRL
      |=> ctrl_q.pol_neg[i] == $past(wb_dat_i[`WMOG_CTRL_POL_LSB + i]))
      else $error("polarity write lost");
  end

  a_pol_invert: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_en_i |=> event_o == ($past(active_d) ^ $past(ctrl_q.pol_neg)))
    else $error("polarity not applied");

  a_pol_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> ctrl_q.pol_neg == 4'h0 && event_o == 4'h0)
    else $error("polarity not positive after reset");

  a_blank_low: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_en_i |=> carrier_suppress_o ==
      ($past(ctrl_q.route_en) && !event_o[$past(ctrl_q.route_sel)]))
    else $error("carrier suppress wrong");

  a_level_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    carrier_suppress_o |-> level_loop_hold_o)
    else $error("level loop not held while suppressed");

  a_hold_between: assert property (@(posedge clk_i) disable iff (rst_i)
    !sample_en_i |=> $stable(event_o) && $stable(carrier_suppress_o))
    else $error("output moved without sample strobe");

  // Every table entry is watched, not just the one being played
  for (genvar s = 0; s < SEG_NUM; s++) begin : g_keep
    a_enable_keep: assert property (@(posedge clk_i) disable iff (rst_i)
      seq_load_i && !wr_go |=> $stable(seg_en_q[s]))
      else $error("sequence load disturbed enables");
  end

  a_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !ack_q |=> ack_q ##1 !ack_q)
    else $error("bus ack not a single cycle");

  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("bus ack held too long");

  a_ack_data: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o == $past(rd_d))
    else $error("read data not valid with ack");

  a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> $past(req))
    else $error("ack without request");

  a_ack_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !req |=> !wb_ack_o)
    else $error("ack while bus idle");

  a_sel_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    req && wb_we_i && ack_q && !wb_sel_i[0]
    |=> $stable(ctrl_q) && $stable(seg_sel_q))
    else $error("write without low byte lane took effect");

  a_status_ro: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && wb_adr_i == `WMOG_ADR_STATUS
    |=> $stable(ctrl_q) && $stable(seg_sel_q))
    else $error("status write changed a register");

  a_sel_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && wb_adr_i == `WMOG_ADR_SEG_SEL
    |=> seg_sel_q == $past(wb_dat_i[SEG_W-1:0]))
    else $error("segment select write lost");

  a_sel_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_go |=> $stable(seg_sel_q))
    else $error("segment select moved without write");

  a_route_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go && wb_adr_i == `WMOG_ADR_CTRL
    |=> ctrl_q.route_en == $past(wb_dat_i[`WMOG_CTRL_RTE_BIT])
    && ctrl_q.route_sel == $past(wb_dat_i[`WMOG_CTRL_RSEL_LSB +: 2]))
    else $error("routing write lost");

  a_ctrl_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_go |=> $stable(ctrl_q))
    else $error("control moved without write");

  a_no_route: assert property (@(posedge clk_i) disable iff (rst_i)
    sample_en_i && !ctrl_q.route_en
    |=> !carrier_suppress_o)
    else $error("carrier suppressed without routing");

  a_hold_equal: assert property (@(posedge clk_i) disable iff (rst_i)
    level_loop_hold_o == carrier_suppress_o)
    else $error("level loop hold differs from suppression");

  a_hold_release: assert property (@(posedge clk_i) disable iff (rst_i)
    !carrier_suppress_o |-> !level_loop_hold_o)
    else $error("level loop held without suppression");

  a_hold_steady: assert property (@(posedge clk_i) disable iff (rst_i)
    !sample_en_i |=> $stable(level_loop_hold_o))
    else $error("level loop hold moved without strobe");

  a_reset_quiet: assert property (@(posedge clk_i)
    $past(rst_i) |-> !carrier_suppress_o && !level_loop_hold_o
    && !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("outputs not quiet after reset");

  a_enable_rst: assert property (@(posedge clk_i)
    $past(rst_i) |-> seg_en_q[seg_idx_i] == `WMOG_SEG_EN_RST)
    else $error("segment enables not restored by reset");

  c_blank: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(carrier_suppress_o));
  c_neg_active: cover property (@(posedge clk_i) disable iff (rst_i)
    sample_en_i && active_d[0] && ctrl_q.pol_neg[0]);
  c_seq_load: cover property (@(posedge clk_i) disable iff (rst_i)
    seq_load_i ##1 sample_en_i && active_d != 4'h0);
  c_seg_masked: cover property (@(posedge clk_i) disable iff (rst_i)
    sample_en_i && playing_i && (eff_bits & ~en_cur) != 4'h0);
  c_factory: cover property (@(posedge clk_i) disable iff (rst_i)
    sample_en_i && playing_i && sample_i.factory && sample_i.first);

endmodule : wmog_marker_gate
`default_nettype wire

// ---- design/wmog_pkg.sv ----
// Types shared by the waveform marker output gate
package wmog_pkg;
  typedef struct packed {
    logic [3:0] bits;
    logic       first;
    logic       factory;
  } wmog_sample_type;

  typedef struct packed {
    logic [3:0] pol_neg;
    logic       route_en;
    logic [1:0] route_sel;
  } wmog_ctrl_type;
endpackage : wmog_pkg

// ---- sim/waveform_marker_output_gating_tb_top.sv ----
// Register-level bench of the marker output gate
`timescale 1ns/1ps
`default_nettype none

module waveform_marker_output_gating_tb_top;
  logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, q, rd;
  logic [3:0] sel = 4'h0, seg = 4'h0, ev;
  logic play = 1'b0, load = 1'b0, sen, plg, ack, sup, hold;
  logic [3:0] sidx;
  wmog_pkg::wmog_sample_type smp = '0, sv;
  int fail_count = 0, total_checks = 0;

  always #2.5 clk = ~clk;

  wmog_play_model i_play (.clk_i(clk), .rst_i(rst), .play_i(play),
    .seg_i(seg), .smp_i(smp), .sample_en_o(sen), .playing_o(plg),
    .seg_idx_o(sidx), .sample_o(sv));

  wmog_marker_gate #(.SEG_W(4)) i_dut (.clk_i(clk), .rst_i(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_ack_o(ack), .wb_dat_o(q),
    .sample_en_i(sen), .playing_i(plg), .seq_load_i(load),
    .seg_idx_i(sidx), .sample_i(sv), .event_o(ev),
    .carrier_suppress_o(sup), .level_loop_hold_o(hold));

  task automatic summarize;
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      $display("BAD %s exp %0h seen %0h", nm, e, s);
      fail_count++;
    end
  endtask : chk

  // Classic cycle: hold everything until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = q;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    if (n >= 20) begin
      fail_count++;
      summarize();
    end
  endtask : wb

  // Drives one sample for long enough that two strobes carry it
  task automatic smp_chk(input logic p, input logic [3:0] s, b,
                         input logic fac, input logic [3:0] e);
    @(posedge clk);
    play <= p; seg <= s; smp <= '{bits: b, first: fac, factory: fac};
    repeat (8) @(posedge clk);
    chk("event", {28'h0, ev}, {28'h0, e});
  endtask : smp_chk

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 32'h0); chk("ctrl", rd, 32'h0);
    wb(1'b0, 8'h08, 32'h0); chk("en0", rd, 32'hF);
    smp_chk(1'b1, 4'h0, 4'h0, 1'b0, 4'h0);
    wb(1'b1, 8'h04, 32'h1); wb(1'b1, 8'h08, 32'h5);
    wb(1'b1, 8'h04, 32'h2); wb(1'b1, 8'h08, 32'hA);
    smp_chk(1'b1, 4'h1, 4'hF, 1'b0, 4'h5);
    smp_chk(1'b1, 4'h2, 4'hF, 1'b0, 4'hA);
    smp_chk(1'b1, 4'h2, 4'h5, 1'b0, 4'h0);
    smp_chk(1'b0, 4'h3, 4'hF, 1'b0, 4'h0);
    @(posedge clk) load <= 1'b1;
    @(posedge clk) load <= 1'b0;
    wb(1'b1, 8'h04, 32'h1); wb(1'b0, 8'h08, 32'h0); chk("en1", rd, 32'h5);
    smp_chk(1'b1, 4'h1, 4'hF, 1'b0, 4'h5);
    smp_chk(1'b1, 4'h3, 4'h0, 1'b1, 4'hF);
    // Markers 0,1 negative, marker 1 routed to carrier suppression
    wb(1'b1, 8'h00, 32'h33);
    smp_chk(1'b1, 4'h3, 4'h1, 1'b0, 4'h2);
    chk("sup", {31'h0, sup}, 32'h0);
    smp_chk(1'b1, 4'h3, 4'h3, 1'b0, 4'h0);
    chk("sup", {31'h0, sup}, 32'h1);
    chk("hold", {31'h0, hold}, 32'h1);
    smp_chk(1'b1, 4'h3, 4'h4, 1'b0, 4'h7);
    chk("hold", {31'h0, hold}, 32'h0);
    wb(1'b1, 8'h0C, 32'hFFFF);
    wb(1'b0, 8'h0C, 32'h0); chk("status", rd, 32'h307);
    wb(1'b1, 8'h10, 32'hFF);
    wb(1'b0, 8'h10, 32'h0); chk("unmapped", rd, 32'h0);
    summarize();
  end
endmodule : waveform_marker_output_gating_tb_top

`default_nettype wire

// ---- sim/wmog_play_model.sv ----
// Playback engine model: strobes one sample every third clock
`timescale 1ns/1ps
`default_nettype none

module wmog_play_model (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      play_i,
  input  wire logic [3:0]                seg_i,
  input  wire wmog_pkg::wmog_sample_type smp_i,
  output logic                           sample_en_o,
  output logic                           playing_o,
  output logic [3:0]                     seg_idx_o,
  output wmog_pkg::wmog_sample_type      sample_o
);
  logic [1:0] cnt_q;

  // Sample data changes only together with its strobe, as a real player
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q       <= 2'h0;
      sample_en_o <= 1'b0;
      playing_o   <= 1'b0;
      seg_idx_o   <= 4'h0;
      sample_o    <= '0;
    end else begin
      cnt_q       <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      sample_en_o <= (cnt_q == 2'h2);
      if (cnt_q == 2'h2) begin
        playing_o <= play_i;
        seg_idx_o <= seg_i;
        sample_o  <= smp_i;
      end
    end
  end
endmodule : wmog_play_model

`default_nettype wire
